// File: verilog/kbc_defs.svh
// register offsets, field positions, reset values, bit count and response codes
`ifndef KBC_DEFS_SVH
`define KBC_DEFS_SVH
`define KBC_OFS_DATA      8'h00
`define KBC_OFS_CTRL      8'h04
`define KBC_OFS_SPLIT     8'h08
`define KBC_OFS_STATUS    8'h0C
`define KBC_CTRL_RESET    8'h00
`define KBC_SPLIT_RESET   4'h0
`define KBC_B_TMR_GATE    0
`define KBC_B_SPK_DATA    1
`define KBC_B_KBD_CLEAR   7
`define KBC_C_TMR_MON     5
`define KBC_ST_IRQ        0
`define KBC_ST_BUSY       1
`define KBC_BIT_COUNT     4'h8
`define KBC_RESP_OKAY     2'b00
`define KBC_RESP_SLVERR   2'b10
`endif

// File: verilog/kbc_pkg.sv
// types shared by the keyboard controller files
package kbc_pkg;
   typedef enum logic [1:0]
   {
      KBC_RX_SHIFT = 2'b00,
      KBC_RX_END   = 2'b01,
      KBC_RX_HOLD  = 2'b10
   } kbc_rx_state_t;
endpackage

// File: verilog/kbc_serial_rx.sv
// serial character receiver on the keyboard link clock
`include "kbc_defs.svh"
module kbc_serial_rx
   import kbc_pkg::*;
(
   input  wire logic       i_link_clock,
   input  wire logic       i_rst_b,
   input  wire logic       i_link_data,
   input  wire logic       i_ack_toggle,
   output logic            o_done_toggle,
   output logic [7:0]      o_data
);
   kbc_rx_state_t state_reg;
   logic [3:0]    count_reg;
   logic [7:0]    shift_reg;
   logic          ack_meta_reg;
   logic          ack_sync_reg;

   // acknowledge toggle from system domain
   always_ff @(posedge i_link_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         ack_meta_reg <= 1'b0;
         ack_sync_reg <= 1'b0;
      end
      else
      begin
         ack_meta_reg <= i_ack_toggle;
         ack_sync_reg <= ack_meta_reg;
      end
   end

   // sample data on each rising link clock edge except while holding a char
   always_ff @(posedge i_link_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         state_reg     <= KBC_RX_SHIFT;
         count_reg     <= 4'h0;
         shift_reg     <= 8'h00;
         o_data        <= 8'h00;
         o_done_toggle <= 1'b0;
      end
      else
      begin
         unique case (state_reg)
            KBC_RX_SHIFT:
            begin
               shift_reg <= {i_link_data, shift_reg[7:1]};
               count_reg <= count_reg + 4'h1;
               if (count_reg == `KBC_BIT_COUNT - 4'h1)
               begin
                  o_data        <= {i_link_data, shift_reg[7:1]};
                  o_done_toggle <= ~o_done_toggle;
                  state_reg     <= KBC_RX_HOLD;
               end
            end
            KBC_RX_HOLD:
            begin
               // ignore edges until host clears busy
               // the rearming edge already carries the first bit
               if (ack_sync_reg == o_done_toggle)
               begin
                  shift_reg <= {i_link_data, shift_reg[7:1]};
                  count_reg <= 4'h1;
                  state_reg <= KBC_RX_SHIFT;
               end
            end
            default:
               state_reg <= KBC_RX_SHIFT;
         endcase
      end
   end
endmodule

// File: verilog/kbc_top.sv
// keyboard controller with three parallel ports on axi4-lite
`include "kbc_defs.svh"
// Summary of operation
// - three 8-bit ports: keyboard data, control output, split port.
// - the keyboard data port is read only and shows the last char.
// - the control port is a latched output steering sound, kbd, timer.
// - the split port has four input bits and four latched output bits.
// - the link is a sender clock line plus a data line.
// - data is sampled on rising edges of the link clock, none while a char is held.
// - data idles high and high means one.
// - after the eighth bit the irq and busy flags are set.
// - the eight bits shift into a byte readable from the bus.
// - one control port bit gates timer counter 2; others run free.
// - timer counter 2 output feeds sound and a split port input bit.
module kbc_top
   import kbc_pkg::*;
(
   input  wire logic        i_clock,
   input  wire logic        i_rst_b,
   input  wire logic        i_link_clock,
   input  wire logic        i_link_data,
   input  wire logic        i_tmr2_out,
   input  wire logic [2:0]  i_split_in,
   output logic             o_tmr2_gate,
   output logic             o_sound_out,
   output logic [7:0]       o_ctrl_port,
   output logic [3:0]       o_split_out,
   output logic             o_kbd_irq,
   output logic             o_kbd_busy,
   input  wire logic [7:0]  i_awaddr,
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   output logic [1:0]       o_bresp,
   output logic             o_bvalid,
   input  wire logic        i_bready,
   input  wire logic [7:0]  i_araddr,
   input  wire logic        i_arvalid,
   output logic             o_arready,
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   output logic             o_rvalid,
   input  wire logic        i_rready
);
   logic        rst_meta_reg;
   logic        rst_sync_reg;
   logic        link_rst_meta_reg;
   logic        link_rst_b_reg;
   logic        done_meta_reg;
   logic        done_sync_reg;
   logic        done_seen_reg;
   logic        ack_toggle_reg;
   logic        rx_done_toggle;
   logic [7:0]  rx_data;
   logic [2:0]  split_meta_reg;
   logic [2:0]  split_sync_reg;
   logic        tmr_meta_reg;
   logic        tmr_sync_reg;
   logic [7:0]  ctrl_reg;
   logic [3:0]  split_out_reg;
   logic        irq_reg;
   logic        busy_reg;
   logic [7:0]  kbd_data_reg;
   logic        aw_held_reg;
   logic        w_held_reg;
   logic [7:0]  awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0]  wstrb_reg;
   logic        wr_go;
   logic        rx_event;
   logic        clear_req;

   // pick the lowest byte lane from the write channel
   function automatic logic [7:0] kbc_lane0(input logic [31:0] d);
      kbc_lane0 = d[7:0];
   endfunction

   // system reset release through two flops
   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   // link-side reset release through two flops
   always_ff @(posedge i_link_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         link_rst_meta_reg <= 1'b0;
         link_rst_b_reg    <= 1'b0;
      end
      else
      begin
         link_rst_meta_reg <= 1'b1;
         link_rst_b_reg    <= link_rst_meta_reg;
      end
   end

   // receiver runs on the sender's clock line
   kbc_serial_rx u_rx
   (
      .i_link_clock  (i_link_clock),
      .i_rst_b       (link_rst_b_reg),
      .i_link_data   (i_link_data),
      .i_ack_toggle  (ack_toggle_reg),
      .o_done_toggle (rx_done_toggle),
      .o_data        (rx_data)
   );

   // character-done toggle crossing into the system clock
   always_ff @(posedge i_clock or negedge rst_sync_reg)
   begin
      if (!rst_sync_reg)
      begin
         done_meta_reg <= 1'b0;
         done_sync_reg <= 1'b0;
         done_seen_reg <= 1'b0;
      end
      else
      begin
         done_meta_reg <= rx_done_toggle;
         done_sync_reg <= done_meta_reg;
         done_seen_reg <= done_sync_reg;
      end
   end

   assign rx_event = done_sync_reg ^ done_seen_reg;

   // pin inputs through two flops
   always_ff @(posedge i_clock or negedge rst_sync_reg)
   begin
      if (!rst_sync_reg)
      begin
         split_meta_reg <= 3'h0;
         split_sync_reg <= 3'h0;
         tmr_meta_reg   <= 1'b0;
         tmr_sync_reg   <= 1'b0;
      end
      else
      begin
         split_meta_reg <= i_split_in;
         split_sync_reg <= split_meta_reg;
         tmr_meta_reg   <= i_tmr2_out;
         tmr_sync_reg   <= tmr_meta_reg;
      end
   end

   // write channel capture, either order
   assign wr_go = aw_held_reg && w_held_reg && !o_bvalid;
   assign o_awready = !aw_held_reg && !o_bvalid;
   assign o_wready  = !w_held_reg && !o_bvalid;

   always_ff @(posedge i_clock or negedge rst_sync_reg)
   begin
      if (!rst_sync_reg)
      begin
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         awaddr_reg  <= 8'h00;
         wdata_reg   <= 32'h0000_0000;
         wstrb_reg   <= 4'h0;
         o_bvalid    <= 1'b0;
         o_bresp     <= `KBC_RESP_OKAY;
      end
      else
      begin
         if (i_awvalid && o_awready)
         begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= i_awaddr;
         end
         if (i_wvalid && o_wready)
         begin
            w_held_reg <= 1'b1;
            wdata_reg  <= i_wdata;
            wstrb_reg  <= i_wstrb;
         end
         if (wr_go)
         begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            o_bvalid    <= 1'b1;
            o_bresp     <= (awaddr_reg == `KBC_OFS_CTRL ||
                            awaddr_reg == `KBC_OFS_SPLIT ||
                            awaddr_reg == `KBC_OFS_DATA ||
                            awaddr_reg == `KBC_OFS_STATUS) ?
                           `KBC_RESP_OKAY : `KBC_RESP_SLVERR;
         end
         else if (o_bvalid && i_bready)
            o_bvalid <= 1'b0;
      end
   end

   // output latches, cleared by reset
   always_ff @(posedge i_clock or negedge rst_sync_reg)
   begin
      if (!rst_sync_reg)
      begin
         ctrl_reg      <= `KBC_CTRL_RESET;
         split_out_reg <= `KBC_SPLIT_RESET;
      end
      else if (wr_go && wstrb_reg[0])
      begin
         if (awaddr_reg == `KBC_OFS_CTRL)
            ctrl_reg <= kbc_lane0(wdata_reg);
         if (awaddr_reg == `KBC_OFS_SPLIT)
            split_out_reg <= wdata_reg[3:0];
      end
   end

   // clear bit written high releases the flags
   assign clear_req = wr_go && wstrb_reg[0] &&
                      awaddr_reg == `KBC_OFS_CTRL &&
                      wdata_reg[`KBC_B_KBD_CLEAR];

   // irq and busy on character end; new event wins over clear
   always_ff @(posedge i_clock or negedge rst_sync_reg)
   begin
      if (!rst_sync_reg)
      begin
         irq_reg        <= 1'b0;
         busy_reg       <= 1'b0;
         kbd_data_reg   <= 8'h00;
         ack_toggle_reg <= 1'b0;
      end
      else if (rx_event)
      begin
         irq_reg      <= 1'b1;
         busy_reg     <= 1'b1;
         kbd_data_reg <= rx_data;
      end
      else if (clear_req && busy_reg)
      begin
         irq_reg        <= 1'b0;
         busy_reg       <= 1'b0;
         ack_toggle_reg <= ~ack_toggle_reg;
      end
   end

   // read channel
   assign o_arready = !o_rvalid;

   always_ff @(posedge i_clock or negedge rst_sync_reg)
   begin
      if (!rst_sync_reg)
      begin
         o_rvalid <= 1'b0;
         o_rdata  <= 32'h0000_0000;
         o_rresp  <= `KBC_RESP_OKAY;
      end
      else if (i_arvalid && o_arready)
      begin
         o_rvalid <= 1'b1;
         o_rresp  <= `KBC_RESP_OKAY;
         unique case (i_araddr)
            `KBC_OFS_DATA:
               o_rdata <= {24'h000000, kbd_data_reg};
            `KBC_OFS_CTRL:
               o_rdata <= {24'h000000, ctrl_reg};
            `KBC_OFS_SPLIT:
               o_rdata <= {24'h000000, tmr_sync_reg, split_sync_reg,
                           split_out_reg};
            `KBC_OFS_STATUS:
               o_rdata <= {30'h0000_0000, busy_reg, irq_reg};
            default:
            begin
               o_rdata <= 32'h0000_0000;
               o_rresp <= `KBC_RESP_SLVERR;
            end
         endcase
      end
      else if (o_rvalid && i_rready)
         o_rvalid <= 1'b0;
   end

   // port pins; counter 2 gated, output also feeds sound
   assign o_tmr2_gate = ctrl_reg[`KBC_B_TMR_GATE];
   assign o_sound_out = ctrl_reg[`KBC_B_SPK_DATA] & tmr_sync_reg;
   assign o_ctrl_port = ctrl_reg;
   assign o_split_out = split_out_reg;
   assign o_kbd_irq   = irq_reg;
   assign o_kbd_busy  = busy_reg;
endmodule

// File: dv/kbc_top_checker.sv
// concurrent checks on the keyboard controller ports
module kbc_top_checker
(
   input  wire logic       i_clock,
   input  wire logic       i_rst_b,
   input  wire logic       i_tmr2_out,
   input  wire logic       o_tmr2_gate,
   input  wire logic       o_sound_out,
   input  wire logic [7:0] o_ctrl_port,
   input  wire logic [3:0] o_split_out,
   input  wire logic       o_kbd_irq,
   input  wire logic       o_kbd_busy,
   input  wire logic       i_awvalid,
   input  wire logic       o_awready,
   input  wire logic       i_wvalid,
   input  wire logic       o_wready,
   input  wire logic       o_bvalid,
   input  wire logic       i_arvalid,
   input  wire logic       o_arready,
   input  wire logic       o_rvalid,
   input  wire logic       i_rready
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);
   gate_follows_ctrl_a: assert property (o_tmr2_gate == o_ctrl_port[0])
      else $error("timer gate differs from control bit");
   sound_path_a: assert property
      (o_sound_out == (o_ctrl_port[1] & $past(i_tmr2_out, 2)))
      else $error("sound output not gated timer output");
   flags_paired_a: assert property (o_kbd_irq == o_kbd_busy)
      else $error("irq and busy disagree");
   flag_clear_a: assert property ($fell(o_kbd_irq) |-> o_ctrl_port[7] || $past(o_ctrl_port[7]))
      else $error("irq dropped without clear");
   reset_clears_a: assert property (disable iff (1'b0) !i_rst_b |-> o_ctrl_port == 8'h00 && o_split_out == 4'h0 && !o_kbd_irq)
      else $error("latches not cleared in reset");
   write_answer_a: assert property
      (i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid)
      else $error("write response late");
   write_refused_a: assert property (o_bvalid |-> !o_awready && !o_wready)
      else $error("write taken while response pending");
   read_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid)
      else $error("read data late");
   read_refused_a: assert property (o_rvalid |-> !o_arready)
      else $error("read taken while data pending");
   read_done_a: assert property (o_rvalid && i_rready |=> !o_rvalid)
      else $error("read data not released");
endmodule

// File: dv/kbc_scan_model.sv
// keyboard scanner model driving the serial link
module kbc_scan_model
(
   output logic o_link_clock,
   output logic o_link_data
);
   timeunit 1ns;
   timeprecision 1ps;
   parameter int HALF = 16;
   initial
   begin
      o_link_clock = 1'b0;
      o_link_data  = 1'b1;
   end
   // n pulses carrying b lsb first; a full frame adds the low end bit
   task automatic frame(input logic [7:0] b, input int n);
      for (int i = 0; i < n; i++)
      begin
         o_link_data = b[i];
         #(HALF / 2);
         o_link_clock = 1'b1;
         #HALF;
         o_link_clock = 1'b0;
         #(HALF / 2);
      end
      if (n == 8)
      begin
         o_link_data = 1'b0;
         #(2 * HALF);
      end
      o_link_data = 1'b1;
      #(2 * HALF);
   endtask
endmodule

// File: dv/kbc_top_test.sv
// self-checking bench for the keyboard controller
`include "kbc_defs.svh"
module kbc_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_clock, i_rst_b, i_tmr2_out, o_tmr2_gate, o_sound_out;
   logic        i_link_clock, i_link_data, o_kbd_irq, o_kbd_busy;
   logic [2:0]  i_split_in;
   logic [7:0]  o_ctrl_port, i_awaddr, i_araddr;
   logic [3:0]  o_split_out, i_wstrb;
   logic        i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid, i_bready;
   logic        i_arvalid, o_arready, o_rvalid, i_rready;
   logic [31:0] i_wdata, o_rdata, v;
   logic [1:0]  o_bresp, o_rresp, r;
   logic [7:0]  chars [4] = '{8'hA5, 8'h00, 8'hFF, 8'h3C};
   int          miscompares = 0;
   int          comparisons = 0;
   int          cycles = 0;
   kbc_top i_dut (.*);
   kbc_scan_model u_scan (.o_link_clock(i_link_clock), .o_link_data(i_link_data));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // waits until the selected answer is seen high before a rising edge
   task automatic hs(input int k);
      do
         @(negedge i_clock);
      while ((k == 0 ? o_arready : k == 1 ? o_rvalid : o_bvalid) !== 1'b1);
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge i_clock);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      hs(0);
      @(posedge i_clock);
      i_arvalid <= 1'b0;
      hs(1);
      v = o_rdata;
      r = o_rresp;
      @(posedge i_clock);
      i_rready <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic pa, pw, ta, tw;
      @(posedge i_clock);
      i_awaddr <= a;
      i_wdata <= d;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      pa = 1'b1;
      pw = 1'b1;
      while (pa || pw)
      begin
         @(negedge i_clock);
         ta = pa && o_awready;
         tw = pw && o_wready;
         @(posedge i_clock);
         if (ta)
            i_awvalid <= 1'b0;
         if (tw)
            i_wvalid <= 1'b0;
         pa = pa && !ta;
         pw = pw && !tw;
      end
      hs(2);
      r = o_bresp;
      @(posedge i_clock);
      i_bready <= 1'b0;
   endtask
   initial
   begin
      i_clock = 1'b0;
      forever
         #5 i_clock = ~i_clock;
   end
   always @(posedge i_clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         miscompares++;
         tally_and_finish();
      end
   end
   initial
   begin
      {i_rst_b, i_tmr2_out, i_awvalid, i_wvalid, i_bready} = 5'h00;
      {i_arvalid, i_rready, i_awaddr, i_araddr, i_wdata} = 0;
      i_wstrb = 4'hF;
      i_split_in = 3'h5;
      repeat (10) @(posedge i_clock);
      i_rst_b <= 1'b1;
      repeat (5) @(posedge i_clock);
      rd(`KBC_OFS_CTRL);
      check(v, {24'h0, `KBC_CTRL_RESET});
      rd(`KBC_OFS_SPLIT);
      check(v, 32'h50);
      rd(`KBC_OFS_STATUS);
      check(v, 32'h0);
      for (int c = 1; c < 4; c++)
      begin
         wr(`KBC_OFS_CTRL, c);
         rd(`KBC_OFS_CTRL);
         check(v, c);
         check({31'h0, o_tmr2_gate}, c & 1);
      end
      i_tmr2_out <= 1'b1;
      wr(`KBC_OFS_SPLIT, 32'h0A);
      rd(`KBC_OFS_SPLIT);
      check(v, 32'hDA);
      check({28'h0, o_split_out}, 32'hA);
      wr(8'h10, 32'h1);
      check(r, `KBC_RESP_SLVERR);
      rd(8'h10);
      check(r, `KBC_RESP_SLVERR);
      foreach (chars[i])
      begin
         u_scan.frame(8'hFF, 2);
         u_scan.frame(chars[i], 8);
         rd(`KBC_OFS_STATUS);
         check(v, 32'h3);
         wr(`KBC_OFS_DATA, ~chars[i]);
         check(r, `KBC_RESP_OKAY);
         rd(`KBC_OFS_DATA);
         check(v, chars[i]);
         u_scan.frame(~chars[i], 8);
         rd(`KBC_OFS_DATA);
         check(v, chars[i]);
         wr(`KBC_OFS_CTRL, 32'h80);
         rd(`KBC_OFS_STATUS);
         check(v, 32'h0);
      end
      tally_and_finish();
   end
endmodule
bind kbc_top kbc_top_checker u_chk (.*);
